// File: rtl/vector_element_layout.sv
// Purpose: element placement, mask bits, scalar routing and vector decode
// Assumes: VLEN and register count are powers of two; APB slave, wait states during element writes
// Notes:   SEW and LMUL are held as log2 codes; LMUL code is signed
// Operation
// - fractional LMUL uses only first LMUL*VLEN/SEW slots
// - fractional tail includes slots past VLMAX
// - groups fill lowest register first, in order
// - element LSB at lowest byte of slot
// - mask always occupies exactly one register
// - mask bit i belongs to element i
// - vector opcodes LOAD-FP, STORE-FP, OP-V
// - memory ops reuse immediate, bit 25 mask
// - vm zero masks by v0, one unmasked
// - scalar source immediate, x, f, element 0
// - scalar result to x, f, element 0
// - any register holds scalar in element 0
// - loads/stores move raw bits unconverted
// - mask-enable bit selects conditional execution
// - finx takes FP scalar from x register
`default_nettype none
module vector_element_layout
    import vlayout_pkg::*;
#(
    parameter int VLENB_LOG = 4,
    parameter int NREG_LOG  = 5,
    parameter int EIDX_W    = 8
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);
    localparam int AW = VLENB_LOG + NREG_LOG;

    // Software state
    logic [31:0]       ctrl_ff;
    logic [EIDX_W-1:0] vl_ff;
    logic [EIDX_W-1:0] elem_ff;
    logic [31:0]       inst_ff;
    logic [31:0]       scalarIn_ff;
    logic [31:0]       scalarOut_ff;
    logic [31:0]       prdata_ff;
    logic [7:0]        maskByte_ff;
    wst_t              state_ff;
    logic [1:0]        byteCnt_ff;
    logic [31:0]       wdata_ff;
    logic              walkWr_ff;
    logic [AW-1:0]     walkAddr_ff;
    logic [1:0]        rdCnt_ff;
    logic [1:0]        rdCntQ_ff;
    logic              rdMaskQ_ff;

    vreg_if #(.AW(AW)) vrf ();

    vreg_store #(.AW(AW)) u_store (
        .mclk (mclk),
        .ce   (ce),
        .port (vrf)
    );

    wire [1:0]          sew    = ctrl_ff[CTRL_SEW_LSB +: 2];
    wire signed [2:0]   lmul   = ctrl_ff[CTRL_LMUL_LSB +: 3];
    wire                vta    = ctrl_ff[CTRL_VTA_BIT];
    wire                finx   = ctrl_ff[CTRL_FINX_BIT];
    wire [1:0]          ssrc   = ctrl_ff[CTRL_SSRC_LSB +: 2];
    wire [1:0]          sdst   = ctrl_ff[CTRL_SDST_LSB +: 2];
    wire [NREG_LOG-1:0] vbase  = ctrl_ff[CTRL_VREG_LSB +: NREG_LOG];

    // Log2 of elements per register for a width code
    function automatic int epr_log(input logic [1:0] s);
        return VLENB_LOG - int'(s);
    endfunction

    // Slots used in one register; fractional LMUL shrinks it
    // fractional slot limit
    wire signed [31:0] eprLog   = epr_log(sew);
    wire signed [31:0] usedLog  = (lmul < 0) ? eprLog + int'(lmul) : eprLog;
    wire signed [31:0] vlmaxLog = eprLog + int'(lmul);
    wire signed [31:0] spanLog  = (vlmaxLog > eprLog) ? vlmaxLog : eprLog;
    wire               usedOk   = usedLog >= 0;

    wire [EIDX_W-1:0]   slot    = EIDX_W'(elem_ff & ((EIDX_W'(1) << eprLog) - EIDX_W'(1)));
    wire [NREG_LOG-1:0] regOfs  = NREG_LOG'(elem_ff >> eprLog);
    wire [NREG_LOG-1:0] regNum  = vbase + regOfs;
    wire [VLENB_LOG-1:0] byteOfs = VLENB_LOG'(slot << sew);
    wire [AW-1:0]        elemAddr = {regNum, byteOfs};

    // tail at or beyond vl, within VLMAX or within the whole register if fractional
    wire inGroup   = usedOk && (32'(elem_ff) < (32'd1 << vlmaxLog));
    wire inSpan    = 32'(elem_ff) < (32'd1 << spanLog);
    wire isTail    = (elem_ff >= vl_ff) && inSpan;
    // Tail-agnostic fills ones; undisturbed leaves the slot alone
    wire tailWrite = isTail && vta;

    wire [6:0] opc     = inst_ff[6:0];
    wire       isLoad  = opc == OPC_LOAD_FP;
    wire       isStore = opc == OPC_STORE_FP;
    wire       isOpV   = opc == OPC_OP_V;
    wire       isVec   = isLoad || isStore || isOpV;
    wire [5:0] memExt  = (isLoad || isStore) ? inst_ff[31:26] : 6'h00;
    wire       vm      = inst_ff[VM_BIT];
    wire       masked  = isVec && !vm;

    // bit i at mask bit i
    wire [AW-1:0] maskAddr = {NREG_LOG'(0), VLENB_LOG'(elem_ff >> 3)};
    wire [2:0]    maskBit  = elem_ff[2:0];
    wire          maskOn   = maskByte_ff[maskBit];
    wire          active   = (elem_ff < vl_ff) && inGroup && (!masked || maskOn);

    // finx redirects FP scalar to x
    wire [1:0] srcEff = (finx && ssrc == SRC_FREG) ? SRC_XREG : ssrc;
    wire [1:0] dstEff = (finx && sdst == DST_FREG) ? DST_XREG : sdst;
    wire [AW-1:0] scalarAddr = {vbase, VLENB_LOG'(0)};

    wire apbSetup = psel && !penable;
    wire apbWr    = psel && penable && pwrite;
    wire apbRd    = psel && penable && !pwrite;
    wire hitCtrl  = paddr == OFS_CTRL;
    wire hitVl    = paddr == OFS_VL;
    wire hitElem  = paddr == OFS_ELEM;
    wire hitInst  = paddr == OFS_INST;
    wire hitPlace = paddr == OFS_PLACE;
    wire hitDec   = paddr == OFS_DECODE;
    wire hitScal  = paddr == OFS_SCALAR;
    wire hitMaskW = paddr == OFS_MASKW;
    wire hitMaskR = paddr == OFS_MASKR;
    wire mapped   = hitCtrl | hitVl | hitElem | hitInst | hitPlace | hitDec
                  | hitScal | hitMaskW | hitMaskR;

    // Element writes walk bytes of the slot, one per cycle
    wire [1:0] bytesLast = 2'((1 << sew) - 1);
    wire startWalk = ce && apbWr && hitScal && state_ff == ST_IDLE;
    wire busy      = state_ff != ST_IDLE;

    // Store walker steers the one byte port
    assign vrf.we    = walkWr_ff;
    assign vrf.waddr = walkAddr_ff;
    assign vrf.wdata = wdata_ff[8*byteCnt_ff +: 8];
    // Idle reads sweep element 0 bytes so the scalar word stays fresh
    assign vrf.raddr = hitMaskR ? maskAddr : (scalarAddr + AW'(rdCnt_ff));

    // Writes stall while a walk is running; read answer is one cycle later
    assign pready  = !busy;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_ff;

    wire [31:0] placeWord = {11'h000, tailWrite, isTail, active, usedOk, inGroup, 16'h0000};
    wire [31:0] decWord   = {16'h0, memExt, srcEff, dstEff,
                             1'b0, masked, isOpV, isStore, isLoad, isVec};

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_ff   <= CTRL_RESET;
            vl_ff     <= '0;
            elem_ff   <= '0;
            inst_ff   <= '0;
            prdata_ff <= '0;
        end
        else if (ce)
        begin
            if (apbWr && !busy)
            begin
                if (hitCtrl) ctrl_ff <= pwdata;
                if (hitVl)   vl_ff   <= EIDX_W'(pwdata);
                if (hitElem) elem_ff <= EIDX_W'(pwdata);
                if (hitInst) inst_ff <= pwdata;
            end
            if (apbSetup)
            begin
                prdata_ff <= hitCtrl  ? ctrl_ff :
                             hitVl    ? 32'(vl_ff) :
                             hitElem  ? 32'(elem_ff) :
                             hitInst  ? inst_ff :
                             hitPlace ? {placeWord[31:16], 16'(elemAddr)} :
                             hitDec   ? decWord :
                             hitScal  ? scalarOut_ff :
                             hitMaskR ? 32'(maskOn) : 32'h0;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_ff     <= ST_IDLE;
            byteCnt_ff   <= '0;
            walkWr_ff    <= 1'b0;
            walkAddr_ff  <= '0;
            wdata_ff     <= '0;
            scalarIn_ff  <= '0;
            scalarOut_ff <= '0;
            maskByte_ff  <= '0;
            rdCnt_ff     <= '0;
            rdCntQ_ff    <= '0;
            rdMaskQ_ff   <= 1'b0;
        end
        else if (ce)
        begin
            maskByte_ff <= vrf.rdata;
            rdCnt_ff    <= rdCnt_ff + 2'h1;
            rdCntQ_ff   <= rdCnt_ff;
            rdMaskQ_ff  <= hitMaskR;
            // Byte lands in its own lane, little-endian
            if (!rdMaskQ_ff)
                scalarOut_ff[8*rdCntQ_ff +: 8] <= vrf.rdata;
            unique case (state_ff)
                ST_IDLE:
                begin
                    walkWr_ff <= 1'b0;
                    if (startWalk)
                    begin
                        wdata_ff    <= tailWrite ? 32'hffff_ffff : pwdata;
                        scalarIn_ff <= pwdata;
                        walkAddr_ff <= (dstEff == DST_VEL0) ? scalarAddr : elemAddr;
                        walkWr_ff   <= active || tailWrite || dstEff == DST_VEL0;
                        byteCnt_ff  <= '0;
                        state_ff    <= ST_WALK;
                    end
                end
                ST_WALK:
                begin
                    if (byteCnt_ff == bytesLast)
                    begin
                        walkWr_ff <= 1'b0;
                        state_ff  <= ST_DONE;
                    end
                    else
                    begin
                        byteCnt_ff  <= byteCnt_ff + 2'h1;
                        walkAddr_ff <= walkAddr_ff + AW'(1);
                    end
                end
                ST_DONE:
                    state_ff <= ST_IDLE;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: pkg/vlayout_pkg.sv
// Purpose: shared constants for vector element placement and decode
// Assumes: 32-bit instructions, APB register access
// Notes:   sizes are log2 codes throughout
`default_nettype none
package vlayout_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_VL     = 8'h04;
    localparam logic [7:0] OFS_ELEM   = 8'h08;
    localparam logic [7:0] OFS_INST   = 8'h0c;
    localparam logic [7:0] OFS_PLACE  = 8'h10;
    localparam logic [7:0] OFS_DECODE = 8'h14;
    localparam logic [7:0] OFS_SCALAR = 8'h18;
    localparam logic [7:0] OFS_MASKW  = 8'h1c;
    localparam logic [7:0] OFS_MASKR  = 8'h20;
    // Control field positions
    localparam int CTRL_SEW_LSB  = 0;
    localparam int CTRL_LMUL_LSB = 2;
    localparam int CTRL_VTA_BIT  = 5;
    localparam int CTRL_FINX_BIT = 6;
    localparam int CTRL_SSRC_LSB = 8;
    localparam int CTRL_SDST_LSB = 10;
    localparam int CTRL_VREG_LSB = 12;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Major opcodes
    localparam logic [6:0] OPC_LOAD_FP  = 7'h07;
    localparam logic [6:0] OPC_STORE_FP = 7'h27;
    localparam logic [6:0] OPC_OP_V     = 7'h57;
    localparam int VM_BIT = 25;
    // Scalar source and destination selectors
    typedef enum logic [1:0] {SRC_IMM = 2'h0, SRC_XREG = 2'h1, SRC_FREG = 2'h2,
                              SRC_VEL0 = 2'h3} ssrc_t;
    typedef enum logic [1:0] {DST_XREG = 2'h0, DST_FREG = 2'h1, DST_VEL0 = 2'h2} sdst_t;
    // Write-back state machine
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_WALK = 3'b010, ST_DONE = 3'b100} wst_t;
endpackage
`default_nettype wire

// File: pkg/vreg_if.sv
// Purpose: port between layout logic and vector register storage
// Assumes: one byte written or read per access
// Notes:   read data registered inside storage
`default_nettype none
interface vreg_if #(parameter int AW = 8);
    logic          we;
    logic [AW-1:0] waddr;
    logic [7:0]    wdata;
    logic [AW-1:0] raddr;
    logic [7:0]    rdata;
    modport ctrl (output we, waddr, wdata, raddr, input rdata);
    modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// File: rtl/vreg_store.sv
// Purpose: byte-wide storage of all vector registers
// Assumes: synchronous write, registered read
// Notes:   contents undefined after reset, like the architecture
`default_nettype none
module vreg_store #(
    parameter int AW = 8
) (
    // Clock
    input  wire logic mclk,
    input  wire logic ce,
    // Access
    vreg_if.mem       port
);
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] rdata_ff;

    always_ff @(posedge mclk)
    begin
        if (ce)
        begin
            if (port.we)
                mem[port.waddr] <= port.wdata;
            rdata_ff <= mem[port.raddr];
        end
    end

    assign port.rdata = rdata_ff;
endmodule
`default_nettype wire

// File: tb/vel_sva.sv
// Purpose: port-level checks of placement, decode and bus answers
// Assumes: ce held high by the bench
// Notes:   shadows CTRL, VL, ELEM and INST from accepted writes
`default_nettype none
module vel_sva
    import vlayout_pkg::*;
#(
    parameter int VLENB_LOG = 4
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic [31:0] ctrl_ff, vl_ff, elem_ff, inst_ff;
    wire        acc     = psel && penable;
    wire        wrOk    = acc && pwrite && pready;
    wire        rdPlace = acc && !pwrite && pready && paddr == OFS_PLACE;
    wire        rdDec   = acc && !pwrite && pready && paddr == OFS_DECODE;
    wire        mapped  = paddr[1:0] == 2'h0 && paddr <= OFS_MASKR;
    wire [4:0]  slotLog = 5'(VLENB_LOG) - {3'h0, ctrl_ff[1:0]} + {{2{ctrl_ff[4]}}, ctrl_ff[4:2]};
    wire        inGroup = elem_ff < (32'h1 << slotLog);
    wire [31:0] span    = ctrl_ff[4] ? (32'h1 << (VLENB_LOG - ctrl_ff[1:0])) : (32'h1 << slotLog);
    wire [15:0] expAddr = 16'((ctrl_ff[16:12] << VLENB_LOG) + (elem_ff << ctrl_ff[1:0]));
    wire        isVec   = inst_ff[6:0] inside {OPC_LOAD_FP, OPC_STORE_FP, OPC_OP_V};
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_ff <= CTRL_RESET;
            vl_ff   <= 32'h0;
            elem_ff <= 32'h0;
            inst_ff <= 32'h0;
        end
        else
        begin
            if (wrOk && paddr == OFS_CTRL)
                ctrl_ff <= pwdata;
            if (wrOk && paddr == OFS_VL)
                vl_ff <= 32'(pwdata[7:0]);
            if (wrOk && paddr == OFS_ELEM)
                elem_ff <= 32'(pwdata[7:0]);
            if (wrOk && paddr == OFS_INST)
                inst_ff <= pwdata;
        end
    end
    sequence s_scalWr;
        wrOk && paddr == OFS_SCALAR;
    endsequence
    sequence s_walk;
        !pready [*2] ##[1:9] pready;
    endsequence
    AST_WALK: assert property (s_scalWr |=> s_walk)
        else $error("scalar write walk wrong length");
    AST_DECODE: assert property (rdDec |-> prdata[0] == isVec
        && prdata[1] == (inst_ff[6:0] == OPC_LOAD_FP) && prdata[3] == (inst_ff[6:0] == OPC_OP_V))
        else $error("vector opcode decode wrong");
    AST_MASKED: assert property (rdDec |-> prdata[4] == (isVec && !inst_ff[VM_BIT]))
        else $error("mask enable decode wrong");
    AST_ADDR: assert property (rdPlace && inGroup |-> prdata[15:0] == expAddr)
        else $error("element byte address wrong");
    AST_GROUP_REG: assert property (rdPlace && !ctrl_ff[4] && inGroup
        |-> 32'(prdata[15:0] >> VLENB_LOG) == ctrl_ff[16:12] + (elem_ff >> slotLog[3:0]) * 0
        + ((elem_ff << ctrl_ff[1:0]) >> VLENB_LOG))
        else $error("group register wrong");
    AST_USED: assert property (rdPlace && ctrl_ff[4] |-> prdata[16] == inGroup)
        else $error("fractional used slot flag wrong");
    AST_TAIL: assert property (rdPlace |-> prdata[19] == (elem_ff >= vl_ff && elem_ff < span))
        else $error("tail flag wrong");
    AST_UNMAPPED: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
endmodule
bind vector_element_layout vel_sva #(.VLENB_LOG(VLENB_LOG)) vel_sva_i (.mclk(mclk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
`default_nettype wire

// File: tb/vec_datapath_model.sv
// Purpose: decode/execute side, presents settings over APB
// Assumes: one transfer in flight
// Notes:   released address and data lines show inverted values; pwrite keeps its last value
`default_nettype none
module vec_datapath_model (
    // Clock
    input  wire logic        mclk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 500);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench for vector element placement
// Assumes: default VLENB_LOG of 4, ce tied high
// Notes:   one task per scenario
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vlayout_pkg::*;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    int          n_errors, num_checks;
    vector_element_layout vector_element_layout_i (.mclk(mclk), .srst(srst), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    vec_datapath_model vec_datapath_model_i (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        vec_datapath_model_i.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        vec_datapath_model_i.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic setup(input logic [1:0] s, input logic [2:0] l, input logic [4:0] b,
                         input logic [31:0] el);
        wr(OFS_CTRL, {15'h0, b, 7'h0, l, s});
        wr(OFS_ELEM, el);
    endtask
    task automatic t_reset();
        rd(OFS_CTRL);
        chk(q, CTRL_RESET);
        rd(8'h40);
        chk({q[30:0], e}, 32'h1);
    endtask
    task automatic t_decode();
        logic [6:0] opc [4] = '{OPC_LOAD_FP, OPC_STORE_FP, OPC_OP_V, 7'h03};
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_INST, {6'h0, i[0], 18'h0, opc[i/2]});
            rd(OFS_DECODE);
            chk(q & 32'h1f, {(i < 6) & ~i[0], i / 2 == 2, i / 2 == 1, i / 2 == 0, i < 6});
        end
        wr(OFS_INST, {6'h2a, 1'b1, 18'h0, OPC_LOAD_FP});
        wr(OFS_CTRL, 32'h0000_0640);
        rd(OFS_DECODE);
        chk(q & 32'hffe0, 32'h0000_a900);
        wr(OFS_CTRL, 32'h0000_0600);
        rd(OFS_DECODE);
        chk(q & 32'hffe0, 32'h0000_aa40);
    endtask
    task automatic t_place();
        int el [3] = '{1, 3, 4};
        for (int s = 0; s < 4; s++)
        begin
            setup(2'(s), 3'(s - 1), 5'h4, 7);
            rd(OFS_PLACE);
            chk(q & 32'hffff, 64 + (7 << s));
        end
        wr(OFS_VL, 2);
        for (int i = 0; i < 3; i++)
        begin
            setup(2'h0, 3'h6, 5'h0, el[i]);
            rd(OFS_PLACE);
            chk(q & 32'h9_0000, {12'h0, i > 0, 2'h0, i < 2, 16'h0});
        end
    endtask
    task automatic t_scalar();
        setup(2'h2, 3'h0, 5'h3, 0);
        wr(OFS_SCALAR, 32'ha1b2c3d4);
        // Read data is taken at setup, so let the walk and sweep finish
        repeat (16) @(posedge mclk);
        rd(OFS_SCALAR);
        chk(q, 32'ha1b2c3d4);
        setup(2'h0, 3'h0, 5'h3, 1);
        rd(OFS_SCALAR);
        chk(q & 32'hff00, 32'hc300);
    endtask
    task automatic t_mask();
        setup(2'h0, 3'h0, 5'h0, 0);
        wr(OFS_SCALAR, 32'h25);
        for (int i = 0; i < 8; i++)
        begin
            setup(2'h2, 3'h1, 5'h0, i);
            // Second read sees refreshed bit
            rd(OFS_MASKR);
            rd(OFS_MASKR);
            chk(q & 32'h1, (32'h25 >> i) & 32'h1);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        srst = 1'b1;
        n_errors = 0;
        num_checks = 0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_decode();
        t_place();
        t_scalar();
        t_mask();
        complete_run();
    end
    initial
    begin
        #50000;
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
